//--- pkg/ssr_pkg.sv
// Package of constants for the supply supervisor reset and watchdog block
package ssr_pkg;
    // ========================================
    // Timebase
    // ========================================
    localparam int unsigned CLK_HZ = 20000000; // Clock rate, 20 MHz
    localparam int unsigned CLK_NS = 50; // Clock period in ns
    // ========================================
    // Timing figures in their own units
    // ========================================
    localparam int unsigned RESET_HOLD_MS = 140; // Reset hold time, plain default
    localparam int unsigned WDT_LONG_S = 35; // Long startup watchdog timeout
    localparam int unsigned WDT_NORM_MS = 1120; // Normal watchdog timeout
    localparam int unsigned PF_DELAY_NS = 2000; // Power-fail update bound
    localparam int unsigned DEBOUNCE_MS = 1; // Manual reset debounce window
    // ========================================
    // Derived cycle counts (64 bit to hold large products)
    // ========================================
    localparam longint unsigned RESET_HOLD_CYC = 64'(RESET_HOLD_MS) * 64'(CLK_HZ) / 64'd1000;
    localparam longint unsigned WDT_LONG_CYC = 64'(WDT_LONG_S) * 64'(CLK_HZ);
    localparam longint unsigned WDT_NORM_CYC = 64'(WDT_NORM_MS) * 64'(CLK_HZ) / 64'd1000;
    localparam longint unsigned PF_DELAY_CYC = 64'(PF_DELAY_NS) / 64'(CLK_NS);
    localparam longint unsigned DEBOUNCE_CYC = 64'(DEBOUNCE_MS) * 64'(CLK_HZ) / 64'd1000;
    // ========================================
    // Widths and reset values
    // ========================================
    localparam int unsigned CNT_W = 32; // Counter width
    localparam logic RST_ACTIVE = 1'b1; // Internal reset state at power-on
endpackage

//--- hw/ssr_debounce.sv
// Manual reset synchroniser and debounce filter
`timescale 1ns/1ps
module ssr_debounce #(
    parameter int unsigned STABLE_CYC = 20000 // Cycles an input must hold to be accepted
) (
    input wire logic mclk_i, // Block clock
    input wire logic rst_i, // Synchronous reset, active high
    input wire logic raw_n_i, // Raw manual reset, active low
    output logic clean_n_o // Debounced manual reset, active low
);
    // ========================================
    // State
    // ========================================
    typedef struct packed {
        logic sync1; // First synchroniser stage
        logic sync2; // Second synchroniser stage
        logic clean; // Accepted level
        logic [31:0] cnt; // Stability counter
    } ssr_deb_type;
    ssr_deb_type st;
    ssr_deb_type next_st;

    // ========================================
    // Next state
    // ========================================
    // A level must hold STABLE_CYC cycles before it replaces the clean one
    always_comb
    begin
        next_st = st;
        next_st.sync1 = raw_n_i;
        next_st.sync2 = st.sync1;
        if (st.sync2 == st.clean)
        begin
            // Agrees with accepted level: restart the window
            next_st.cnt = '0;
        end
        else if (st.cnt >= 32'(STABLE_CYC - 1))
        begin
            // Held long enough: accept it, so bounce gives one clean edge
            next_st.clean = st.sync2;
            next_st.cnt = '0;
        end
        else
        begin
            next_st.cnt = st.cnt + 32'd1;
        end
    end

    // ========================================
    // Registers
    // ========================================
    // Idle level is high: an open input reads as no manual reset
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            st <= '{sync1: 1'b1, sync2: 1'b1, clean: 1'b1, cnt: 32'h0};
        end
        else
        begin
            st <= next_st;
        end
    end

    assign clean_n_o = st.clean;

    // Clean level only moves after a full stable window
    clean_stable_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        $changed(st.clean) |-> $past(st.cnt) == 32'(STABLE_CYC - 1))
        else $error("debounced level changed early");
endmodule

//--- hw/ssr_supervisor.sv
// Supply supervisor: reset generation, dual-mode watchdog and power-fail output
`timescale 1ns/1ps
module ssr_supervisor #(
    parameter longint unsigned RESET_HOLD_CYC = ssr_pkg::RESET_HOLD_CYC, // Reset hold in cycles
    parameter longint unsigned WDT_LONG_CYC = ssr_pkg::WDT_LONG_CYC, // Startup watchdog in cycles
    parameter longint unsigned WDT_NORM_CYC = ssr_pkg::WDT_NORM_CYC, // Normal watchdog in cycles
    parameter int unsigned DEBOUNCE_CYC = 32'(ssr_pkg::DEBOUNCE_CYC) // Manual reset filter
) (
    input wire logic mclk_i, // Block clock, 20 MHz
    input wire logic rst_i, // Synchronous reset, active high
    input wire logic primary_supply_low_i, // Primary supply below threshold
    input wire logic secondary_supply_low_i, // Secondary supply below threshold
    input wire logic aux_undervoltage_sense_i, // Auxiliary input below threshold
    input wire logic power_fail_sense_i, // Power-fail comparator says below reference
    input wire logic manual_reset_n_i, // Manual reset, active low
    input wire logic watchdog_kick_i, // Watchdog input from the processor
    output logic reset_out_o, // Active-high reset
    output logic reset_out_a_n_o, // Active-low reset, first output
    output logic reset_out_b_n_o, // Active-low reset, second output
    output logic power_fail_out_n_o // Active-low power-fail output
);
    // ========================================
    // State types
    // ========================================
    typedef enum logic [2:0] {
        SSR_HOLD = 3'h1, // Reset asserted, counting the hold time
        SSR_LONG = 3'h2, // Running, startup watchdog timeout
        SSR_NORM = 3'h4 // Running, normal watchdog timeout
    } ssr_mode_type;

    typedef struct packed {
        ssr_mode_type mode; // Sequencer state
        logic [63:0] hold_cnt; // Reset hold counter
        logic [63:0] wdt_cnt; // Watchdog counter
        logic kick_s1; // Kick synchroniser first stage
        logic kick_s2; // Kick synchroniser second stage
        logic kick_prev; // Last synchronised kick level
        logic reset_state; // One internal reset state
        logic reset_state_n; // Complement copy, so the low outputs leave a flop too
        logic pf_n; // Power-fail output register
    } ssr_state_type;

    ssr_state_type st;
    ssr_state_type next_st;
    logic mr_clean_n; // Debounced manual reset
    logic fault; // Any level cause of reset
    logic kick_edge; // Watchdog input changed level
    logic wdt_expired; // Watchdog counter ran out

    // ========================================
    // Manual reset filter
    // ========================================
    ssr_debounce #(
        .STABLE_CYC(DEBOUNCE_CYC)
    ) u_deb (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .raw_n_i(manual_reset_n_i),
        .clean_n_o(mr_clean_n)
    );

    // ========================================
    // Cause decode
    // ========================================
    // Level causes; the watchdog adds a single event on top
    assign fault = primary_supply_low_i | secondary_supply_low_i
        | aux_undervoltage_sense_i | ~mr_clean_n;
    assign kick_edge = st.kick_s2 ^ st.kick_prev;
    // Expiry limit follows the current mode
    assign wdt_expired = (st.mode == SSR_LONG) ? (st.wdt_cnt >= WDT_LONG_CYC - 64'd1)
        : (st.wdt_cnt >= WDT_NORM_CYC - 64'd1);

    // ========================================
    // Next state
    // ========================================
    always_comb
    begin
        next_st = st;
        next_st.kick_s1 = watchdog_kick_i;
        next_st.kick_s2 = st.kick_s1;
        next_st.kick_prev = st.kick_s2;
        // Comparator result goes straight through, no hold
        next_st.pf_n = ~power_fail_sense_i;
        case (st.mode)
            SSR_HOLD:
            begin
                next_st.wdt_cnt = '0;
                if (fault)
                begin
                    next_st.hold_cnt = '0;
                end
                else if (st.hold_cnt >= RESET_HOLD_CYC - 64'd1)
                begin
                    // Hold done: release and start in the long watchdog mode
                    next_st.mode = SSR_LONG;
                    next_st.reset_state = 1'b0;
                    next_st.hold_cnt = '0;
                end
                else
                begin
                    next_st.hold_cnt = st.hold_cnt + 64'd1;
                end
            end
            SSR_LONG, SSR_NORM:
            begin
                if (fault || wdt_expired)
                begin
                    // Any event returns to hold for one full reset hold time
                    next_st.mode = SSR_HOLD;
                    next_st.reset_state = 1'b1;
                    next_st.hold_cnt = '0;
                    next_st.wdt_cnt = '0;
                end
                else if (kick_edge)
                begin
                    next_st.mode = SSR_NORM;
                    next_st.wdt_cnt = '0;
                end
                else
                begin
                    next_st.wdt_cnt = st.wdt_cnt + 64'd1;
                end
            end
            default:
            begin
                next_st.mode = SSR_HOLD;
                next_st.reset_state = 1'b1;
                next_st.hold_cnt = '0;
            end
        endcase
        // Derived from the final next value so both flops can never disagree
        next_st.reset_state_n = ~next_st.reset_state;
    end

    // ========================================
    // Registers
    // ========================================
    // Reset comes up asserted, as at power-up
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            st <= '{mode: SSR_HOLD, hold_cnt: 64'h0, wdt_cnt: 64'h0, kick_s1: 1'b0,
                kick_s2: 1'b0, kick_prev: 1'b0, reset_state: ssr_pkg::RST_ACTIVE,
                reset_state_n: ~ssr_pkg::RST_ACTIVE, pf_n: 1'b1};
        end
        else
        begin
            st <= next_st;
        end
    end

    // Outputs come straight from flip-flops, the two active-low resets both from reset_state_n
    assign reset_out_o = st.reset_state;
    assign reset_out_a_n_o = st.reset_state_n;
    assign reset_out_b_n_o = st.reset_state_n;
    assign power_fail_out_n_o = st.pf_n;

    // ========================================
    // Assertions
    // ========================================
    sequence cause_seen;
        fault;
    endsequence

    // Watchdog runs out while the processor is running
    sequence wdt_fire;
        !reset_out_o && wdt_expired;
    endsequence

    // Reset stays up for at least eight cycles of its hold
    sequence reset_run;
        reset_out_o [*8];
    endsequence

    pf_follow_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        ##1 power_fail_out_n_o == ~$past(power_fail_sense_i))
        else $error("power-fail output not following sense");
    pf_release_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        $fell(power_fail_sense_i) |=> power_fail_out_n_o)
        else $error("power-fail release delayed");
    pf_delay_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        $changed(power_fail_sense_i) |-> ##[1:40] power_fail_out_n_o == ~power_fail_sense_i)
        else $error("power-fail output too slow");
    fault_reset_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        cause_seen |=> reset_out_o && !reset_out_a_n_o)
        else $error("reset not asserted on fault");
    hold_restart_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (st.mode == SSR_HOLD) and cause_seen |=> st.hold_cnt == 64'h0)
        else $error("hold counter not restarted");
    hold_full_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        $fell(reset_out_o) |-> $past(st.hold_cnt) == RESET_HOLD_CYC - 64'd1)
        else $error("reset released before full hold");
    out_compl_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        reset_out_a_n_o == ~reset_out_o && reset_out_b_n_o == reset_out_a_n_o)
        else $error("reset outputs disagree");
    wdt_expire_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        !reset_out_o && wdt_expired |=> reset_out_o)
        else $error("watchdog expiry missed");
    wdt_clear_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        !reset_out_o && !fault && !wdt_expired && kick_edge |=> st.wdt_cnt == 64'h0 && st.mode == SSR_NORM)
        else $error("kick did not clear watchdog");
    long_after_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        $fell(reset_out_o) |-> st.mode == SSR_LONG)
        else $error("startup mode not long");
    wdt_held_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        reset_out_o |-> st.wdt_cnt == 64'h0)
        else $error("watchdog counting during reset");
    wdt_pulse_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        wdt_fire |=> reset_run)
        else $error("watchdog reset pulse too short");
endmodule

//--- test/ssr_cpu_model.sv
// Behavioural processor that receives reset and toggles the watchdog input
`timescale 1ns/1ps
module ssr_cpu_model (
    input wire logic mclk_i, // Block clock
    input wire logic reset_n_i, // Reset seen by the processor, active low
    input wire logic kick_en_i, // Software loop alive
    input wire logic [7:0] kick_period_i, // Cycles between toggles
    output logic kick_o // Watchdog input level
);
    logic [7:0] gap; // Cycles since last toggle
    initial
    begin
        kick_o = 1'b0;
        gap = 8'h00;
    end
    // ========================================
    // Toggle loop
    // ========================================
    // A held processor cannot run code, so no toggles while reset is low
    always @(posedge mclk_i)
    begin
        if (!reset_n_i || !kick_en_i)
            gap <= 8'h00;
        else if (gap + 8'h01 >= kick_period_i)
        begin
            gap <= 8'h00;
            kick_o <= ~kick_o; // Either edge counts as a kick
        end
        else
            gap <= gap + 8'h01;
    end
endmodule

//--- test/ssr_supervisor_bench.sv
// Self-checking bench for the supply supervisor with a processor model
`timescale 1ns/1ps
module ssr_supervisor_bench;
    localparam int HOLD = 20; // Short reset hold
    localparam int WL = 200; // Short startup watchdog
    localparam int WN = 50; // Short normal watchdog
    localparam int DEB = 4; // Short manual filter
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [2:0] flt = 3'h0; // Aux, secondary, primary faults
    logic pf_sense = 1'b0;
    logic man_n = 1'b1; // Idle high, as the pull-up leaves it
    logic kick_en = 1'b0;
    logic [7:0] kick_period = 8'h10;
    logic kick, rst_hi, rst_a_n, rst_b_n, pf_n;
    int failures = 0;
    int checks = 0;
    int cyc = 0;
    int n;
    initial
    begin
        forever #25 mclk_i = ~mclk_i;
    end
    ssr_supervisor #(.RESET_HOLD_CYC(HOLD), .WDT_LONG_CYC(WL), .WDT_NORM_CYC(WN), .DEBOUNCE_CYC(DEB)) u_dut (
        .mclk_i(mclk_i), .rst_i(rst_i), .primary_supply_low_i(flt[0]), .secondary_supply_low_i(flt[1]),
        .aux_undervoltage_sense_i(flt[2]), .power_fail_sense_i(pf_sense), .manual_reset_n_i(man_n),
        .watchdog_kick_i(kick), .reset_out_o(rst_hi), .reset_out_a_n_o(rst_a_n), .reset_out_b_n_o(rst_b_n),
        .power_fail_out_n_o(pf_n));
    ssr_cpu_model u_cpu (.mclk_i(mclk_i), .reset_n_i(rst_a_n), .kick_en_i(kick_en),
        .kick_period_i(kick_period), .kick_o(kick));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [31:0] in_win(input int v, input int lo, input int hi);
        return (v >= lo && v <= hi) ? 32'h1 : 32'h0;
    endfunction
    // Counts falling edges until the reset output shows v, or the limit
    task automatic wait_lvl(input logic v, input int lim, output int k);
        k = 0;
        do
        begin
            @(negedge mclk_i);
            k++;
        end
        while (rst_hi !== v && k < lim);
    endtask
    task automatic cycles(input int k);
        repeat (k) @(posedge mclk_i);
    endtask
    task automatic give_verdict();
        if (failures == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ========================================
    // Output pairing watch
    // ========================================
    always @(negedge mclk_i)
    begin
        check(rst_a_n, {~rst_hi});
        check(rst_b_n, rst_a_n);
    end
    // Hang guard, well above the expected run length
    always @(posedge mclk_i)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            failures++;
            give_verdict();
        end
    end
    // ========================================
    // Main sequence
    // ========================================
    initial
    begin
        void'($urandom(32'h74c4));
        cycles(15);
        @(negedge mclk_i);
        check(rst_hi, 1);
        check(rst_a_n, 0);
        check(pf_n, 1);
        @(posedge mclk_i);
        rst_i <= 1'b0;
        wait_lvl(1'b0, HOLD + 10, n);
        check(in_win(n, HOLD - 1, HOLD + 4), 1);
        @(posedge mclk_i);
        kick_period <= 8'($urandom_range(40, 5));
        kick_en <= 1'b1;
        // Power fail follows its sense with no hold and never resets
        repeat (4)
        begin
            @(posedge mclk_i);
            pf_sense <= 1'b1;
            cycles(1 + $urandom_range(6));
            @(negedge mclk_i);
            check(pf_n, 0);
            check(rst_hi, 0);
            @(posedge mclk_i);
            pf_sense <= 1'b0;
            cycles(1);
            @(negedge mclk_i);
            check(pf_n, 1);
        end
        // Each supply cause, with a repeat fault inside the hold
        for (int c = 0; c < 3; c++)
        begin
            @(posedge mclk_i);
            flt[c] <= 1'b1;
            cycles(1 + $urandom_range(4));
            @(negedge mclk_i);
            check(rst_hi, 1);
            @(posedge mclk_i);
            flt[c] <= 1'b0;
            cycles(HOLD / 2);
            flt[c] <= 1'b1;
            @(posedge mclk_i);
            flt[c] <= 1'b0;
            wait_lvl(1'b0, HOLD * 3, n);
            check(in_win(n, HOLD - 1, HOLD + 4), 1);
        end
        // Bounces shorter than the filter must not reset
        repeat (3)
        begin
            @(posedge mclk_i);
            man_n <= 1'b0;
            cycles(2);
            man_n <= 1'b1;
            cycles(1);
        end
        @(negedge mclk_i);
        check(rst_hi, 0);
        @(posedge mclk_i);
        man_n <= 1'b0;
        cycles(HOLD * 3);
        @(negedge mclk_i);
        check(rst_hi, 1);
        @(posedge mclk_i);
        man_n <= 1'b1;
        cycles(1);
        man_n <= 1'b0;
        cycles(1);
        man_n <= 1'b1;
        wait_lvl(1'b0, HOLD * 3, n);
        check(in_win(n, HOLD + DEB, HOLD + DEB + 8), 1);
        // Watchdog: silent processor after a brownout meets the long period
        @(posedge mclk_i);
        kick_en <= 1'b0;
        flt[0] <= 1'b1;
        @(posedge mclk_i);
        flt[0] <= 1'b0;
        wait_lvl(1'b1, 5, n);
        wait_lvl(1'b0, HOLD + 10, n);
        wait_lvl(1'b1, WL + 20, n);
        check(in_win(n, WL - 2, WL + 4), 1);
        wait_lvl(1'b0, HOLD + 10, n);
        check(in_win(n, HOLD - 1, HOLD + 4), 1);
        // One toggle switches to the short period
        cycles(30);
        kick_period <= 8'h01;
        kick_en <= 1'b1;
        @(posedge mclk_i);
        kick_en <= 1'b0;
        wait_lvl(1'b1, WN + 20, n);
        check(in_win(n, WN - 2, WN + 8), 1);
        wait_lvl(1'b0, HOLD + 10, n);
        wait_lvl(1'b1, WL + 20, n);
        check(in_win(n, WL - 2, WL + 4), 1);
        wait_lvl(1'b0, HOLD + 10, n);
        // Regular toggles keep reset away, stopping them trips it
        @(posedge mclk_i);
        kick_period <= 8'($urandom_range(40, 5));
        kick_en <= 1'b1;
        wait_lvl(1'b1, 300, n);
        check(n, 300);
        @(posedge mclk_i);
        kick_en <= 1'b0;
        wait_lvl(1'b1, WN + 20, n);
        check(in_win(n, WN - 42, WN + 6), 1);
        give_verdict();
    end
endmodule
